// File: trb_pkg.sv
package trb_pkg;
   localparam int unsigned CLK_MHZ = 200;
   localparam int unsigned DIV_F8 = 8;
   localparam int unsigned DIV_F2 = 2;
   localparam logic [9:0] OFS_CONTROL = 10'h108;
   localparam logic [9:0] OFS_ONESHOT = 10'h109;
   localparam logic [9:0] OFS_IO_CONTROL = 10'h10a;
   localparam logic [9:0] OFS_MODE_CONFIG = 10'h10b;
   localparam logic [9:0] OFS_PRESCALER = 10'h10c;
   localparam logic [9:0] OFS_SECONDARY = 10'h10d;
   localparam logic [9:0] OFS_PRIMARY = 10'h10e;
   localparam logic [9:0] OFS_IRQ_STATUS = 10'h110;
   localparam logic [9:0] OFS_IRQ_CLEAR = 10'h111;
   localparam logic [9:0] OFS_IRQ_ENABLE = 10'h112;
   localparam int unsigned MODE_LSB = 0;
   localparam int unsigned WRC_BIT = 3;
   localparam int unsigned SRC_LSB = 4;
   localparam int unsigned CUT_BIT = 7;
   localparam int unsigned START_BIT = 0;
   localparam int unsigned STATUS_BIT = 1;
   localparam int unsigned STOP_BIT = 2;
   localparam int unsigned OST_START_BIT = 0;
   localparam int unsigned OST_STOP_BIT = 1;
   localparam int unsigned OST_STATUS_BIT = 2;
   localparam int unsigned OUT_LEVEL_BIT = 0;
   localparam int unsigned OUT_SWITCH_BIT = 1;
   localparam int unsigned TRIG_EN_BIT = 2;
   localparam int unsigned TRIG_POL_BIT = 3;
   localparam int unsigned IRQ_UNDER_BIT = 0;
   localparam int unsigned IRQ_DONE_BIT = 1;
   localparam logic [7:0] RESET_VAL = 8'h00;
   localparam logic [7:0] RELOAD_RESET = 8'hff;
   localparam logic [7:0] IO_MASK = 8'h0f;
   localparam logic [7:0] MODE_MASK = 8'hbb;
   localparam logic [7:0] IRQ_MASK = 8'h03;
   typedef enum logic [1:0] {
      MODE_TIMER = 2'h0,
      MODE_WAVE = 2'h1,
      MODE_ONESHOT = 2'h2,
      MODE_WAIT_ONESHOT = 2'h3
   } trb_mode_t;
   typedef enum logic [1:0] {
      SRC_F1 = 2'h0,
      SRC_F8 = 2'h1,
      SRC_OTHER = 2'h2,
      SRC_F2 = 2'h3
   } trb_src_t;
endpackage

// File: trb_tick_if.sv
`timescale 1ns/1ps
interface trb_tick_if;
   logic [1:0] src_sel;
   logic gate_off;
   logic other_underflow;
   logic tick;
   modport gen (input src_sel, input gate_off, input other_underflow,
      output tick);
   modport use_side (output src_sel, output gate_off,
      output other_underflow, input tick);
endinterface

// File: trb_tick_gen.sv
`timescale 1ns/1ps
module trb_tick_gen
   import trb_pkg::*;
(
   input wire logic ref_clk, // clock
   input wire logic rst, // sync reset
   trb_tick_if.gen tk // source select and tick
);
   logic [2:0] div_reg;
   logic [2:0] div_next;
   logic sel_tick;

   always_comb begin
      div_next = div_reg + 3'h1;
      if (div_reg == 3'(DIV_F8 - 1)) begin
         div_next = 3'h0;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         div_reg <= 3'h0;
      end else begin
         div_reg <= div_next;
      end
   end

   always_comb begin
      unique case (trb_src_t'(tk.src_sel))
         SRC_F1: sel_tick = 1'b1;
         SRC_F8: sel_tick = (div_reg == 3'(DIV_F8 - 1));
         SRC_OTHER: sel_tick = tk.other_underflow;
         SRC_F2: sel_tick = div_reg[0];
      endcase
      tk.tick = sel_tick & ~tk.gate_off;
   end
endmodule

// File: trb_timer.sv
// Chosen here: the strobed register port.
`timescale 1ns/1ps
// How it works
// - an 8-bit prescaler feeds an 8-bit timer, each a reload and counter.
// - the timer reloads from a primary or a secondary reload register.
// - every count and reload moves only on a selected count-source tick.
// - mode bits 1:0 pick timer, waveform, one-shot or delayed one-shot.
// - one-shot modes give one pulse per trigger, the wait mode delayed.
// - waveform mode outputs pulses with primary/secondary widths forever.
// - write-control bit 3 at 0 writes reload and counter, at 1 reload only while running.
// - source bits 5:4 pick f1, f8, the other timer's underflow or f2.
// - cutoff bit 7 at 1 blocks the count source.
// - the io control keeps four bits 3:0 and reads zero in bits 7:4.
// - timer mode reloads the primary on underflow and raises a request.
// - timer mode divides by (prescaler+1)*(timer+1).
// - writing start 1 starts; start 0 or forced stop 1 stops counting.
module trb_timer
   import trb_pkg::*;
#(
   parameter int unsigned WIDTH = 8
)(
   input wire logic ref_clk, // 200 MHz clock
   input wire logic rst, // sync reset, high
   input wire logic [9:0] addr, // register address
   input wire logic [7:0] wdata, // write data
   input wire logic wr, // write strobe
   input wire logic rd, // read strobe
   output logic [7:0] rdata, // read data, cycle after rd
   input wire logic other_underflow, // other timer underflow pulse
   input wire logic trig_in, // one-shot trigger pin
   output logic wave_out, // timer output pin level
   output logic underflow, // underflow pulse
   output logic irq // level interrupt
);
   trb_tick_if tk();

   logic [7:0] io_reg, io_next;
   logic [7:0] mode_reg, mode_next;
   logic start_reg, start_next;
   logic run_reg, run_next;
   logic ost_reg, ost_next;
   logic [WIDTH-1:0] pre_rl_reg, pre_rl_next;
   logic [WIDTH-1:0] pre_cnt_reg, pre_cnt_next;
   logic [WIDTH-1:0] pri_rl_reg, pri_rl_next;
   logic [WIDTH-1:0] sec_rl_reg, sec_rl_next;
   logic [WIDTH-1:0] tmr_cnt_reg, tmr_cnt_next;
   logic phase_reg, phase_next;
   logic out_reg, out_next;
   logic trig_d_reg;
   logic [1:0] ist_reg, ist_next;
   logic [1:0] ien_reg, ien_next;
   logic [7:0] rdata_reg, rdata_next;
   logic uf_reg, uf_next;
   logic wave_reg, wave_next;

   logic tick, pre_uf, tmr_uf, trig_edge, both_write, shot_done;
   trb_mode_t mode;

   trb_tick_gen u_tick (
      .ref_clk (ref_clk),
      .rst (rst),
      .tk (tk.gen)
   );

   function automatic logic wr_hit(input logic [9:0] a);
      return wr && (addr == a);
   endfunction

   function automatic logic [WIDTH-1:0] dec(input logic [WIDTH-1:0] v);
      return v - WIDTH'(1);
   endfunction

   function automatic logic is_shot(input trb_mode_t m);
      return m == MODE_ONESHOT || m == MODE_WAIT_ONESHOT;
   endfunction

   ////////////////////////////////////////////////////////////////////////////

   assign tk.src_sel = mode_reg[SRC_LSB+:2];
   assign tk.gate_off = mode_reg[CUT_BIT];
   assign tk.other_underflow = other_underflow;
   assign mode = trb_mode_t'(mode_reg[MODE_LSB+:2]);

   always_comb begin
      // counting only on a gated tick while running
      tick = tk.tick & run_reg;
      pre_uf = tick && (pre_cnt_reg == '0);
      tmr_uf = pre_uf && (tmr_cnt_reg == '0);
      trig_edge = (trig_in ^ trig_d_reg) &
         (trig_in ^ io_reg[TRIG_POL_BIT]) & io_reg[TRIG_EN_BIT];
      both_write = ~run_reg | ~mode_reg[WRC_BIT];
      // last underflow of a shot, delay phase already spent
      shot_done = tmr_uf && is_shot(mode) &&
         (mode == MODE_ONESHOT || phase_reg);
   end

   ////////////////////////////////////////////////////////////////////////////

   always_comb begin
      io_next = io_reg;
      mode_next = mode_reg;
      start_next = start_reg;
      ost_next = ost_reg;
      if (wr_hit(OFS_IO_CONTROL)) begin
         io_next = wdata & IO_MASK;
      end
      // mode, source and cutoff accepted only while stopped
      if (wr_hit(OFS_MODE_CONFIG)) begin
         if (!start_reg && !run_reg) begin
            mode_next = wdata & MODE_MASK;
         end else begin
            mode_next[WRC_BIT] = wdata[WRC_BIT];
         end
      end
      if (wr_hit(OFS_CONTROL)) begin
         start_next = wdata[START_BIT] & ~wdata[STOP_BIT];
      end
      if (wr_hit(OFS_ONESHOT)) begin
         if (wdata[OST_START_BIT]) begin
            ost_next = 1'b1;
         end
         if (wdata[OST_STOP_BIT]) begin
            ost_next = 1'b0;
         end
      end
      // a finished shot waits for a fresh trigger
      if (shot_done) begin
         ost_next = 1'b0;
      end
      if (trig_edge && start_reg) begin
         ost_next = 1'b1;
      end
      if (wr_hit(OFS_CONTROL) && wdata[STOP_BIT]) begin
         ost_next = 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////

   always_comb begin
      run_next = start_reg;
      if (is_shot(mode)) begin
         run_next = start_reg & ost_reg;
      end
      pre_rl_next = pre_rl_reg;
      pre_cnt_next = pre_cnt_reg;
      pri_rl_next = pri_rl_reg;
      sec_rl_next = sec_rl_reg;
      tmr_cnt_next = tmr_cnt_reg;
      phase_next = phase_reg;
      out_next = out_reg;
      uf_next = 1'b0;
      if (tick) begin
         pre_cnt_next = pre_uf ? pre_rl_reg : dec(pre_cnt_reg);
      end
      if (pre_uf) begin
         tmr_cnt_next = dec(tmr_cnt_reg);
      end
      if (tmr_uf) begin
         uf_next = 1'b1;
         unique case (mode)
            MODE_TIMER: begin
               tmr_cnt_next = pri_rl_reg;
            end
            MODE_WAVE: begin
               // alternate primary and secondary widths
               tmr_cnt_next = phase_reg ? pri_rl_reg : sec_rl_reg;
               phase_next = ~phase_reg;
               out_next = ~out_reg;
            end
            MODE_ONESHOT, MODE_WAIT_ONESHOT: begin
               // two phases: optional delay then pulse
               tmr_cnt_next = phase_reg ? pri_rl_reg : sec_rl_reg;
               phase_next = ~phase_reg;
               if (mode == MODE_ONESHOT || phase_reg) begin
                  tmr_cnt_next = pri_rl_reg;
                  phase_next = 1'b0;
                  out_next = 1'b0;
                  run_next = 1'b0;
               end else begin
                  out_next = 1'b1;
               end
            end
         endcase
      end
      if (!run_reg && !tick) begin
         if (mode == MODE_ONESHOT && ost_reg && start_reg) begin
            out_next = 1'b1;
         end
         if (!ost_reg) begin
            phase_next = 1'b0;
         end
      end
      if (wr_hit(OFS_PRESCALER)) begin
         pre_rl_next = wdata;
         if (both_write) begin
            pre_cnt_next = wdata;
         end
      end
      if (wr_hit(OFS_PRIMARY)) begin
         pri_rl_next = wdata;
         if (both_write) begin
            tmr_cnt_next = wdata;
         end
      end
      if (wr_hit(OFS_SECONDARY)) begin
         sec_rl_next = wdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////////

   always_comb begin
      ien_next = ien_reg;
      ist_next = ist_reg;
      if (wr_hit(OFS_IRQ_ENABLE)) begin
         ien_next = wdata[1:0];
      end
      if (wr_hit(OFS_IRQ_CLEAR)) begin
         ist_next = ist_reg & ~wdata[1:0];
      end
      // set wins over clear
      if (tmr_uf) begin
         ist_next[IRQ_UNDER_BIT] = 1'b1;
      end
      if (shot_done) begin
         ist_next[IRQ_DONE_BIT] = 1'b1;
      end
   end

   always_comb begin
      rdata_next = 8'h00;
      if (rd) begin
         unique case (addr)
            OFS_CONTROL: begin
               rdata_next[START_BIT] = start_reg;
               rdata_next[STATUS_BIT] = run_reg;
            end
            OFS_ONESHOT: begin
               rdata_next[OST_START_BIT] = ost_reg;
               rdata_next[OST_STATUS_BIT] = run_reg;
            end
            OFS_IO_CONTROL: rdata_next = io_reg & IO_MASK;
            OFS_MODE_CONFIG: rdata_next = mode_reg & MODE_MASK;
            OFS_PRESCALER: rdata_next = pre_cnt_reg;
            OFS_SECONDARY: rdata_next = sec_rl_reg;
            OFS_PRIMARY: rdata_next = tmr_cnt_reg;
            OFS_IRQ_STATUS: rdata_next = {6'h00, ist_reg};
            OFS_IRQ_ENABLE: rdata_next = {6'h00, ien_reg};
            default: rdata_next = 8'h00;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////

   // config, start and trigger history
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         io_reg <= RESET_VAL;
         mode_reg <= RESET_VAL;
         start_reg <= 1'b0;
         ost_reg <= 1'b0;
         trig_d_reg <= 1'b0;
      end else begin
         io_reg <= io_next;
         mode_reg <= mode_next;
         start_reg <= start_next;
         ost_reg <= ost_next;
         trig_d_reg <= trig_in;
      end
   end

   // counters, reloads and the output phase
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         run_reg <= 1'b0;
         pre_rl_reg <= RELOAD_RESET;
         pre_cnt_reg <= RELOAD_RESET;
         pri_rl_reg <= RELOAD_RESET;
         sec_rl_reg <= RELOAD_RESET;
         tmr_cnt_reg <= RELOAD_RESET;
         phase_reg <= 1'b0;
         out_reg <= 1'b0;
         uf_reg <= 1'b0;
      end else begin
         run_reg <= run_next;
         pre_rl_reg <= pre_rl_next;
         pre_cnt_reg <= pre_cnt_next;
         pri_rl_reg <= pri_rl_next;
         sec_rl_reg <= sec_rl_next;
         tmr_cnt_reg <= tmr_cnt_next;
         phase_reg <= phase_next;
         out_reg <= out_next;
         uf_reg <= uf_next;
      end
   end

   // interrupt status and enable
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         ist_reg <= 2'h0;
         ien_reg <= 2'h0;
      end else begin
         ist_reg <= ist_next;
         ien_reg <= ien_next;
      end
   end

   // read data for one cycle after the strobe
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         rdata_reg <= 8'h00;
      end else begin
         rdata_reg <= rdata_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////

   // output switch picks timer waveform or the level bit
   always_comb begin
      wave_next = io_reg[OUT_SWITCH_BIT] ? io_reg[OUT_LEVEL_BIT] :
         (out_reg ^ io_reg[OUT_LEVEL_BIT]);
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         wave_reg <= 1'b0;
      end else begin
         wave_reg <= wave_next;
      end
   end

   always_comb begin
      rdata = rdata_reg;
      underflow = uf_reg;
      irq = |(ist_reg & ien_reg);
      wave_out = wave_reg;
   end
endmodule

// File: trb_timer_sva.sv
`timescale 1ns/1ps
module trb_timer_sva
   import trb_pkg::*;
#(
   parameter int unsigned WIDTH = 8
)(
   input wire logic ref_clk, // clock
   input wire logic rst, // reset
   input wire logic [9:0] addr, // address
   input wire logic [7:0] wdata, // write data
   input wire logic wr, // write strobe
   input wire logic rd, // read strobe
   input wire logic [7:0] rdata, // read data
   input wire logic other_underflow, // other timer
   input wire logic trig_in, // trigger pin
   input wire logic wave_out, // output pin
   input wire logic underflow, // underflow pulse
   input wire logic irq // interrupt
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);
   logic run_reg, run_next;
   logic [4:0] idle_reg, idle_next;
   logic [3:0] io_reg, io_next;
   logic [1:0] age_reg, age_next;
   ////////////////////////////////////////////////////////////////////////
   // shadow of start request and io bits
   always_comb begin
      run_next = run_reg;
      io_next = io_reg;
      age_next = age_reg + {1'b0, age_reg != 2'h3};
      if (wr && addr == OFS_CONTROL) begin
         run_next = wdata[START_BIT] && !wdata[STOP_BIT];
      end
      if (wr && addr == OFS_IO_CONTROL) begin
         io_next = wdata[3:0];
         age_next = 2'h0;
      end
      idle_next = run_reg ? 5'h00 : idle_reg + {4'h0, idle_reg != 5'h1f};
   end
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         run_reg <= 1'b0;
         idle_reg <= 5'h00;
         io_reg <= 4'h0;
         age_reg <= 2'h0;
      end else begin
         run_reg <= run_next;
         idle_reg <= idle_next;
         io_reg <= io_next;
         age_reg <= age_next;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   sequence s_rd(logic [9:0] a);
      rd && addr == a;
   endsequence
   sequence s_mask_off;
      wr && addr == OFS_IRQ_ENABLE && wdata == 8'h00;
   endsequence
   a_rdata_idle: assert property (!rd |=> rdata == 8'h00)
      else $error("read data not zero while idle");
   a_io_readback: assert property (s_rd(OFS_IO_CONTROL) |=>
      rdata == {4'h0, io_reg}) else $error("io readback wrong");
   a_mode_holes: assert property (s_rd(OFS_MODE_CONFIG) |=>
      (rdata & ~MODE_MASK) == 8'h00) else $error("mode holes not zero");
   a_clear_reads: assert property (s_rd(OFS_IRQ_CLEAR) |=> rdata == 8'h00)
      else $error("clear register read not zero");
   a_unmapped_zero: assert property (rd && addr == 10'h10f |=>
      rdata == 8'h00) else $error("unmapped read not zero");
   a_irq_masked: assert property (s_mask_off |-> ##[1:2] !irq)
      else $error("irq high with all enables off");
   a_stop_quiet: assert property (idle_reg == 5'h1f |-> !underflow)
      else $error("underflow while stopped");
   a_out_forced: assert property (age_reg == 2'h3 &&
      io_reg[OUT_SWITCH_BIT] |-> wave_out == io_reg[OUT_LEVEL_BIT])
      else $error("forced output level wrong");
endmodule
bind trb_timer trb_timer_sva #(.WIDTH(WIDTH)) u_sva (.ref_clk(ref_clk),
   .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
   .other_underflow(other_underflow), .trig_in(trig_in),
   .wave_out(wave_out), .underflow(underflow), .irq(irq));

// File: tb_eight_bit_reload_timer_b.sv
`timescale 1ns/1ps
module tb_eight_bit_reload_timer_b;
   import trb_pkg::*;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic [9:0] addr = 10'h000;
   logic [7:0] wdata = 8'h00;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic other_underflow = 1'b0;
   logic trig_in = 1'b0;
   logic [7:0] rdata;
   logic wave_out, underflow, irq, ext_on = 1'b0, a;
   logic [1:0] oc = 2'h0;
   int error_cnt = 0, check_count = 0, n;
   logic [9:0] ta [13] = '{10'h10a, 10'h10a, 10'h10b, 10'h10b, 10'h10b,
      10'h10b, 10'h10b, 10'h10b, 10'h10c, 10'h10e, 10'h112, 10'h111, 10'h10f};
   logic [7:0] td [13] = '{8'hff, 8'h05, 8'hff, 8'h00, 8'h11, 8'h22, 8'h33,
      8'h88, 8'h12, 8'h34, 8'h03, 8'hff, 8'h5a};
   logic [7:0] te [13] = '{8'h0f, 8'h05, 8'hbb, 8'h00, 8'h11, 8'h22, 8'h33,
      8'h88, 8'h12, 8'h34, 8'h03, 8'h00, 8'h00};
   always #2.5 ref_clk = ~ref_clk;
   // other timer underflow every third cycle
   always @(posedge ref_clk) begin
      oc <= (oc == 2'h2) ? 2'h0 : oc + 2'h1;
      other_underflow <= ext_on && oc == 2'h0;
   end
   trb_timer uut (.ref_clk(ref_clk), .rst(rst), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rdata(rdata), .other_underflow(other_underflow),
      .trig_in(trig_in), .wave_out(wave_out), .underflow(underflow),
      .irq(irq));
   ////////////////////////////////////////////////////////////////////////
   task automatic report_and_stop;
      $display("checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [7:0] s, e);
      check_count++;
      if (s !== e) begin
         error_cnt++;
         $display("[FAIL] %s exp %h got %h", nm, e, s);
      end
   endtask
   task automatic wr_reg(input logic [9:0] ad, input logic [7:0] d);
      @(posedge ref_clk);
      wr <= 1'b1;
      addr <= ad;
      wdata <= d;
      @(posedge ref_clk);
      wr <= 1'b0;
   endtask
   task automatic rchk(input string nm, input logic [9:0] ad, logic [7:0] e);
      @(posedge ref_clk);
      rd <= 1'b1;
      addr <= ad;
      @(posedge ref_clk);
      rd <= 1'b0;
      #1 chk(nm, rdata, e);
   endtask
   task automatic wait_uf(output int c);
      c = 0;
      do begin
         @(posedge ref_clk);
         #1 c++;
      end while (underflow !== 1'b1 && c < 400);
      if (c >= 400) begin
         error_cnt++;
         report_and_stop;
      end
   endtask
   task automatic count_uf(input int cyc, output int c);
      c = 0;
      repeat (cyc) begin
         @(posedge ref_clk);
         #1 c += (underflow === 1'b1);
      end
   endtask
   task automatic run(input logic [7:0] m);
      wr_reg(OFS_CONTROL, 8'h00);
      repeat (12) @(posedge ref_clk);
      wr_reg(OFS_MODE_CONFIG, m);
      wr_reg(OFS_CONTROL, 8'h01);
   endtask
   task automatic period(input logic [7:0] e, input string nm);
      wait_uf(n);
      wait_uf(n);
      chk(nm, n[7:0], e);
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (10) @(posedge ref_clk);
      rst <= 1'b0;
      rchk("io", OFS_IO_CONTROL, RESET_VAL);
      rchk("mode", OFS_MODE_CONFIG, RESET_VAL);
      rchk("pre", OFS_PRESCALER, RELOAD_RESET);
      rchk("pri", OFS_PRIMARY, RELOAD_RESET);
      for (int i = 0; i < 13; i++) begin
         wr_reg(ta[i], td[i]);
         rchk("row", ta[i], te[i]);
      end
      wr_reg(OFS_PRESCALER, 8'h01);
      wr_reg(OFS_PRIMARY, 8'h02);
      wr_reg(OFS_IRQ_ENABLE, 8'h01);
      run(8'h00);
      period(8'd6, "f1 period");
      wr_reg(OFS_CONTROL, 8'h00);
      repeat (12) @(posedge ref_clk);
      #1 chk("irq", {7'h0, irq}, 8'h01);
      rchk("status", OFS_IRQ_STATUS, 8'h01);
      wr_reg(OFS_IRQ_ENABLE, 8'h00);
      wr_reg(OFS_IRQ_ENABLE, 8'h01);
      wr_reg(OFS_IRQ_CLEAR, 8'h01);
      repeat (2) @(posedge ref_clk);
      #1 chk("irq clr", {7'h0, irq}, 8'h00);
      run(8'h10);
      period(8'd48, "f8 period");
      run(8'h30);
      period(8'd12, "f2 period");
      ext_on <= 1'b1;
      run(8'h20);
      period(8'd18, "other period");
      ext_on <= 1'b0;
      run(8'h80);
      count_uf(100, n);
      chk("cut", n[7:0], 8'h00);
      wr_reg(OFS_PRESCALER, 8'hff);
      wr_reg(OFS_PRIMARY, 8'h02);
      run(8'h08);
      wr_reg(OFS_PRIMARY, 8'h00);
      rchk("reload only", OFS_PRIMARY, 8'h02);
      wr_reg(OFS_MODE_CONFIG, 8'h01);
      rchk("mode locked", OFS_MODE_CONFIG, 8'h00);
      wr_reg(OFS_PRIMARY, 8'h07);
      rchk("both", OFS_PRIMARY, 8'h07);
      wr_reg(OFS_CONTROL, 8'h04);
      repeat (12) @(posedge ref_clk);
      rchk("stopped", OFS_CONTROL, 8'h00);
      wr_reg(OFS_PRESCALER, 8'h01);
      wr_reg(OFS_PRIMARY, 8'h02);
      wr_reg(OFS_IO_CONTROL, 8'h04);
      run(8'h02);
      trig_in <= 1'b1;
      count_uf(100, n);
      chk("one shot", n[7:0], 8'h01);
      trig_in <= 1'b0;
      wr_reg(OFS_IO_CONTROL, 8'h00);
      wr_reg(OFS_SECONDARY, 8'h01);
      run(8'h01);
      wait_uf(n);
      repeat (3) @(posedge ref_clk);
      #1 a = wave_out;
      wait_uf(n);
      repeat (3) @(posedge ref_clk);
      #1 chk("wave", {7'h0, wave_out}, {7'h0, ~a});
      wr_reg(OFS_IO_CONTROL, 8'h03);
      repeat (3) @(posedge ref_clk);
      #1 chk("forced", {7'h0, wave_out}, 8'h01);
      wr_reg(OFS_CONTROL, 8'h00);
      // reset after a stop write clears flags, output and config
      rst <= 1'b1;
      repeat (2) @(posedge ref_clk);
      rst <= 1'b0;
      #1 chk("rst irq", {7'h0, irq}, 8'h00);
      chk("rst out", {7'h0, wave_out}, 8'h00);
      rchk("rst mode", OFS_MODE_CONFIG, RESET_VAL);
      report_and_stop;
   end
endmodule
